/* File: rtl/cxr_exception_unit.sv */
// Exception and reset sequencer of the core
`timescale 1ns/10ps
module cxr_exception_unit #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
  parameter logic HAS_MAC = 1'b0,
  parameter logic HAS_DIV = 1'b1,
  parameter logic HAS_ENHANCED_MULTIPLY_ACCUM_PRESENT = 1'b0,
  parameter logic HAS_CAU = 1'b0,
  parameter logic [3:0] FLASH_SIZE_CODE = 4'h0,
  parameter logic [3:0] RAM_SIZE_CODE = 4'h0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic force_reset_i,
  input wire logic ctl_we_i,
  input wire logic vbr_we_i,
  input wire logic [31:0] ctl_wdata_i,
  input wire logic op_valid_i,
  input wire logic [15:0] opword_i,
  input wire logic op_undef_i,
  input wire logic op_rte_i,
  input wire logic op_trap_i,
  input wire logic [3:0] op_trap_num_i,
  input wire logic [31:0] op_pc_i,
  input wire logic [31:0] sp_i,
  input wire logic bkpt_i,
  input wire logic fault_i,
  input wire logic exc_done_i,
  input wire logic irq_pending_i,
  input wire logic [2:0] irq_level_i,
  input wire logic [7:0] irq_vector_i,
  input wire logic interrupt_acknowledge_cycle_done_i,
  input wire logic [7:0] interrupt_acknowledge_cycle_vector_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic interrupt_acknowledge_cycle_req_o,
  output logic exc_take_o,
  output logic [7:0] exc_vector_o,
  output logic [31:0] exc_pc_o,
  output logic exc_keep_frame_o,
  output logic pc_load_o,
  output logic [31:0] pc_o,
  output logic sp_load_o,
  output logic [31:0] sp_o,
  output logic [15:0] status_word_o,
  output logic [31:0] vector_base_o,
  output logic [31:0] cpu_control_word_o,
  output logic [31:0] core_config_word_o,
  output logic [31:0] mem_config_word_o,
  output logic reset_req_o,
  output logic halted_o
);

  // Size codes beyond the defined tables cannot be reported
  if (RAM_SIZE_CODE > 4'h9 || FLASH_SIZE_CODE > 4'hb) begin : g_bad_size
    $error("Memory size code out of range");
  end

  cxr_pkg::cxr_state_e state_r, state_nxt;
  logic soft_rst_r, soft_nxt;
  logic [2:0] ctl_r;
  logic [15:0] sr_r;
  logic [31:0] vbr_r;
  logic busy_r, boot_r;
  logic [2:0] lvl_r;
  logic [15:0] rte_sr_r;
  logic [31:0] rte_pc_r;
  logic [31:0] addr_r;
  logic [3:0] fmt_r;
  logic take, keep, irq_go, ret_go;
  logic [7:0] vec;
  logic rst_all, illegal_reset_disable, address_reset_disable, ack_cycle_enable, line_af, irq_ok;
  logic [3:0] line;
  logic [2:0] irq_lvl;

  // Legal frame format check
  function automatic logic valid_fmt(input logic [3:0] f);
    valid_fmt = (f >= cxr_pkg::FMT_MIN) && (f <= cxr_pkg::FMT_MAX);
  endfunction

  assign rst_all = !rst_n_i || force_reset_i || soft_rst_r;
  assign illegal_reset_disable = ctl_r[cxr_pkg::CTL_IRD_POS];
  assign address_reset_disable = ctl_r[cxr_pkg::CTL_ARD_POS];
  assign ack_cycle_enable = ctl_r[cxr_pkg::CTL_IAE_POS];
  assign line = opword_i[15:12];
  assign line_af = op_undef_i && (line == cxr_pkg::LINE_A || line == cxr_pkg::LINE_F);
  // Level 7 cannot be masked
  assign irq_ok = irq_pending_i &&
                  (irq_level_i > sr_r[cxr_pkg::SR_I_LSB +: 3] || irq_level_i == cxr_pkg::IPL_MAX);
  assign irq_lvl = (state_r == cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE) ? lvl_r : irq_level_i;

  // Sequencer decisions, priority fixed by order of tests
  always_comb begin
    state_nxt = state_r;
    take = 1'b0;
    vec = 8'h00;
    soft_nxt = 1'b0;
    keep = 1'b0;
    irq_go = 1'b0;
    ret_go = 1'b0;
    unique case (state_r)
      cxr_pkg::ST_CFG: begin
        state_nxt = cxr_pkg::ST_RSP;
      end
      cxr_pkg::ST_RSP, cxr_pkg::ST_RPC: begin
        if (mem_err_i || fault_i) begin
          state_nxt = cxr_pkg::ST_HALT;
        end else if (mem_ack_i) begin
          state_nxt = (state_r == cxr_pkg::ST_RSP) ? cxr_pkg::ST_RPC : cxr_pkg::ST_RUN;
        end
      end
      cxr_pkg::ST_RUN: begin
        if (fault_i && (boot_r || busy_r)) begin
          if (boot_r || address_reset_disable) begin
            state_nxt = cxr_pkg::ST_HALT;
          end else begin
            soft_nxt = 1'b1;
          end
        end else if (bkpt_i) begin
          take = 1'b1;
          vec = cxr_pkg::VEC_DEBUG;
        end else if (op_valid_i) begin
          if (line_af) begin
            if (illegal_reset_disable) begin
              take = 1'b1;
              vec = (line == cxr_pkg::LINE_A) ? cxr_pkg::VEC_LINE_A : cxr_pkg::VEC_LINE_F;
            end else begin
              soft_nxt = 1'b1;
            end
          end else if (op_rte_i) begin
            state_nxt = cxr_pkg::ST_RTE1;
          end else if (op_trap_i) begin
            take = 1'b1;
            vec = cxr_pkg::VEC_TRAP_BASE + {4'h0, op_trap_num_i};
          end else if (irq_ok) begin
            if (ack_cycle_enable) begin
              state_nxt = cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
            end else begin
              take = 1'b1;
              vec = irq_vector_i;
              irq_go = 1'b1;
            end
          end
        end
      end
      cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE: begin
        if (interrupt_acknowledge_cycle_done_i) begin
          take = 1'b1;
          vec = interrupt_acknowledge_cycle_vector_i;
          irq_go = 1'b1;
          state_nxt = cxr_pkg::ST_RUN;
        end
      end
      cxr_pkg::ST_RTE1: begin
        if (mem_err_i) begin
          take = 1'b1;
          vec = cxr_pkg::VEC_ACCESS;
          state_nxt = cxr_pkg::ST_RUN;
        end else if (mem_ack_i) begin
          if (valid_fmt(mem_rdata_i[cxr_pkg::FRM_FMT_LSB +: 4])) begin
            state_nxt = cxr_pkg::ST_RTE2;
          end else begin
            state_nxt = cxr_pkg::ST_RUN;
            if (address_reset_disable) begin
              take = 1'b1;
              vec = cxr_pkg::VEC_FORMAT;
              keep = 1'b1;
            end else begin
              soft_nxt = 1'b1;
            end
          end
        end
      end
      cxr_pkg::ST_RTE2: begin
        if (mem_err_i) begin
          take = 1'b1;
          vec = cxr_pkg::VEC_ACCESS;
          state_nxt = cxr_pkg::ST_RUN;
        end else if (mem_ack_i) begin
          ret_go = 1'b1;
          state_nxt = cxr_pkg::ST_RUN;
        end
      end
      cxr_pkg::ST_HALT: begin
        state_nxt = cxr_pkg::ST_HALT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      state_r <= cxr_pkg::ST_CFG;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-cycle internal reset request, not retriggered while active
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_nxt && !rst_all;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      ctl_r <= cxr_pkg::CTL_RESET;
      vbr_r <= cxr_pkg::VBR_RESET;
    end else begin
      if (ctl_we_i) begin
        ctl_r <= ctl_wdata_i[2:0];
      end
      if (vbr_we_i) begin
        vbr_r <= ctl_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      sr_r <= cxr_pkg::SR_RESET;
    end else if (take) begin
      sr_r[cxr_pkg::SR_S_POS] <= 1'b1;
      sr_r[cxr_pkg::SR_T_POS] <= 1'b0;
      if (irq_go) begin
        sr_r[cxr_pkg::SR_M_POS] <= 1'b0;
        sr_r[cxr_pkg::SR_I_LSB +: 3] <= irq_lvl;
      end
    end else if (ret_go) begin
      sr_r <= rte_sr_r;
    end
  end

  // Busy marks exception processing; set wins over done
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      busy_r <= 1'b0;
      boot_r <= 1'b1;
    end else begin
      busy_r <= take || (busy_r && !exc_done_i);
      if (state_r == cxr_pkg::ST_RUN && op_valid_i) begin
        boot_r <= 1'b0;
      end
    end
  end

  // Interrupt level held across the acknowledge wait
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      lvl_r <= 3'h0;
    end else if (state_r == cxr_pkg::ST_RUN && state_nxt == cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE) begin
      lvl_r <= irq_level_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      addr_r <= cxr_pkg::RST_SP_ADDR;
    end else if (state_r == cxr_pkg::ST_RSP && mem_ack_i) begin
      addr_r <= cxr_pkg::RST_PC_ADDR;
    end else if (state_nxt == cxr_pkg::ST_RTE1 && state_r == cxr_pkg::ST_RUN) begin
      addr_r <= sp_i;
    end else if (state_nxt == cxr_pkg::ST_RTE2 && state_r == cxr_pkg::ST_RTE1) begin
      addr_r <= addr_r + cxr_pkg::LWORD_BYTES;
    end
  end

  // Return frame capture
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      rte_sr_r <= cxr_pkg::SR_RESET;
      rte_pc_r <= 32'h0000_0000;
    end else begin
      if (state_r == cxr_pkg::ST_RUN && state_nxt == cxr_pkg::ST_RTE1) begin
        rte_pc_r <= op_pc_i;
      end
      if (state_r == cxr_pkg::ST_RTE1 && mem_ack_i) begin
        rte_sr_r <= mem_rdata_i[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      pc_load_o <= 1'b0;
      sp_load_o <= 1'b0;
      pc_o <= 32'h0000_0000;
      sp_o <= 32'h0000_0000;
    end else begin
      pc_load_o <= ret_go || (state_r == cxr_pkg::ST_RPC && mem_ack_i && !mem_err_i && !fault_i);
      sp_load_o <= ret_go || (state_r == cxr_pkg::ST_RSP && mem_ack_i && !mem_err_i && !fault_i);
      if (state_r == cxr_pkg::ST_RSP && mem_ack_i) begin
        sp_o <= mem_rdata_i;
      end
      if (state_r == cxr_pkg::ST_RPC || ret_go) begin
        pc_o <= mem_rdata_i;
      end
      // Step past first longword, then add the format value
      if (ret_go) begin
        sp_o <= addr_r + {28'h0, fmt_r};
      end
    end
  end

  // Format of the frame being returned through
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      fmt_r <= 4'h0;
    end else if (state_r == cxr_pkg::ST_RTE1 && mem_ack_i) begin
      fmt_r <= mem_rdata_i[cxr_pkg::FRM_FMT_LSB +: 4];
    end
  end

  // Exception request to the stacking logic
  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      exc_take_o <= 1'b0;
      exc_vector_o <= 8'h00;
      exc_pc_o <= 32'h0000_0000;
      exc_keep_frame_o <= 1'b0;
    end else begin
      exc_take_o <= take;
      exc_keep_frame_o <= keep;
      if (take) begin
        exc_vector_o <= vec;
        exc_pc_o <= (state_r == cxr_pkg::ST_RTE1 || state_r == cxr_pkg::ST_RTE2) ? rte_pc_r : op_pc_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_all) begin
      core_config_word_o <= 32'h0000_0000;
      mem_config_word_o <= 32'h0000_0000;
    end else if (state_r == cxr_pkg::ST_CFG) begin
      core_config_word_o <= {FAMILY_CODE, cxr_pkg::CFG_GEN, cxr_pkg::CFG_REV,
                             HAS_MAC, HAS_DIV, HAS_ENHANCED_MULTIPLY_ACCUM_PRESENT, 1'b0, 1'b0, HAS_CAU, 2'b00,
                             cxr_pkg::CFG_ISA, cxr_pkg::CFG_DBG};
      mem_config_word_o <= {cxr_pkg::CFG1_MARK, 4'h0, FLASH_SIZE_CODE, 4'h0,
                            cxr_pkg::CFG1_MARK, 4'h0, RAM_SIZE_CODE, 4'h0};
    end
  end

  // Handshakes straight from state
  assign mem_req_o = (state_r == cxr_pkg::ST_RSP) || (state_r == cxr_pkg::ST_RPC) ||
                     (state_r == cxr_pkg::ST_RTE1) || (state_r == cxr_pkg::ST_RTE2);
  assign mem_addr_o = addr_r;
  assign interrupt_acknowledge_cycle_req_o = (state_r == cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE);
  assign halted_o = (state_r == cxr_pkg::ST_HALT);
  assign reset_req_o = soft_rst_r;
  assign status_word_o = sr_r;
  assign vector_base_o = vbr_r;
  assign cpu_control_word_o = {29'h0, ctl_r};

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_all);

  logic run_op;
  assign run_op = state_r == cxr_pkg::ST_RUN && op_valid_i && !fault_i && !bkpt_i;

  a_line_a_vec: assert property (run_op && line_af && illegal_reset_disable && line == cxr_pkg::LINE_A
    |=> exc_take_o && exc_vector_o == cxr_pkg::VEC_LINE_A) else $error("Line A vector wrong");
  a_line_f_vec: assert property (run_op && line_af && illegal_reset_disable && line == cxr_pkg::LINE_F
    |=> exc_take_o && exc_vector_o == cxr_pkg::VEC_LINE_F) else $error("Line F vector wrong");
  // The request resets the unit itself, so only outside resets may cut this check short
  a_illegal_reset: assert property (disable iff (!rst_n_i || force_reset_i)
    run_op && line_af && !illegal_reset_disable && !reset_req_o |=> reset_req_o && !exc_take_o)
    else $error("Illegal opcode reset missing");
  a_debug_keeps_mask: assert property (state_r == cxr_pkg::ST_RUN && bkpt_i && !fault_i
    |=> exc_take_o && exc_vector_o == cxr_pkg::VEC_DEBUG && !interrupt_acknowledge_cycle_req_o
        && status_word_o[12:8] == $past(status_word_o[12:8])) else $error("Debug interrupt wrong");
  sequence s_fmt_bad;
    state_r == cxr_pkg::ST_RTE1 && mem_ack_i && !mem_err_i && !valid_fmt(mem_rdata_i[31:28]);
  endsequence
  a_format_error: assert property (s_fmt_bad and address_reset_disable
    |=> exc_take_o && exc_keep_frame_o && exc_vector_o == cxr_pkg::VEC_FORMAT) else $error("Format error lost");
  a_format_pc: assert property (exc_keep_frame_o |-> exc_pc_o == rte_pc_r)
    else $error("Format error PC wrong");
  a_format_reset: assert property (disable iff (!rst_n_i || force_reset_i)
    s_fmt_bad and !address_reset_disable && !reset_req_o |=> reset_req_o)
    else $error("Format error reset missing");
  sequence s_ret_done;
    state_r == cxr_pkg::ST_RTE2 && mem_ack_i && !mem_err_i;
  endsequence
  a_return_load: assert property (s_ret_done |=> pc_load_o && sp_load_o
    && status_word_o == $past(rte_sr_r) && sp_o == $past(addr_r) + {28'h0, $past(fmt_r)})
    else $error("Return load wrong");
  a_trap_vec: assert property (run_op && !line_af && !op_rte_i && op_trap_i
    |=> exc_take_o && exc_vector_o == cxr_pkg::VEC_TRAP_BASE + {4'h0, $past(op_trap_num_i)})
    else $error("Trap vector wrong");
  a_irq_level: assert property (state_r == cxr_pkg::ST_INTERRUPT_ACKNOWLEDGE_CYCLE && interrupt_acknowledge_cycle_done_i
    |=> !status_word_o[12] && status_word_o[10:8] == $past(lvl_r)) else $error("Interrupt mask wrong");
  a_irq_sample: assert property ($rose(interrupt_acknowledge_cycle_req_o) |-> $past(op_valid_i))
    else $error("Interrupt sampled off instruction");
  a_halt_sticky: assert property (halted_o |=> halted_o) else $error("Halt left without reset");
  a_reset_state: assert property (state_r == cxr_pkg::ST_CFG
    |-> status_word_o == cxr_pkg::SR_RESET && vector_base_o == 32'h0 && cpu_control_word_o == 32'h0)
    else $error("Reset state wrong");
  a_boot_reads: assert property (state_r == cxr_pkg::ST_RSP && mem_ack_i && !mem_err_i && !fault_i
    |=> mem_addr_o == cxr_pkg::RST_PC_ADDR && $past(mem_addr_o) == cxr_pkg::RST_SP_ADDR && sp_load_o
        && sp_o == $past(mem_rdata_i)) else $error("Boot read order wrong");
  a_boot_fault: assert property (state_r == cxr_pkg::ST_RUN && boot_r && fault_i |=> halted_o)
    else $error("Boot fault not halted");
  a_config_load: assert property (state_r == cxr_pkg::ST_CFG
    |=> core_config_word_o[31:16] == {FAMILY_CODE, cxr_pkg::CFG_GEN, cxr_pkg::CFG_REV}
        && core_config_word_o[7:0] == {cxr_pkg::CFG_ISA, cxr_pkg::CFG_DBG}) else $error("Config word wrong");

endmodule

/* File: rtl/cxr_pkg.sv */
// Shared constants for the core exception and reset unit
package cxr_pkg;
  // Opword line codes
  localparam logic [3:0] LINE_A = 4'ha;
  localparam logic [3:0] LINE_F = 4'hf;
  // Vector numbers
  localparam logic [7:0] VEC_ACCESS = 8'h02;
  localparam logic [7:0] VEC_LINE_A = 8'h0a;
  localparam logic [7:0] VEC_LINE_F = 8'h0b;
  localparam logic [7:0] VEC_DEBUG = 8'h0c;
  localparam logic [7:0] VEC_FORMAT = 8'h0e;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  // Legal exception return frame formats
  localparam logic [3:0] FMT_MIN = 4'h4;
  localparam logic [3:0] FMT_MAX = 4'h7;
  localparam int FRM_FMT_LSB = 28;
  // Status word layout and reset value
  localparam int SR_T_POS = 15;
  localparam int SR_S_POS = 13;
  localparam int SR_M_POS = 12;
  localparam int SR_I_LSB = 8;
  localparam logic [2:0] IPL_MAX = 3'h7;
  localparam logic [15:0] SR_RESET = 16'h2700;
  // Control word fields and reset values
  localparam int CTL_IRD_POS = 0;
  localparam int CTL_ARD_POS = 1;
  localparam int CTL_IAE_POS = 2;
  localparam logic [2:0] CTL_RESET = 3'h0;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  // Reset fetch addresses and longword step
  localparam logic [31:0] RST_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_PC_ADDR = 32'h0000_0004;
  localparam logic [31:0] LWORD_BYTES = 32'h0000_0004;
  // Configuration word fields
  localparam logic [3:0] CFG_GEN = 4'h1;
  localparam logic [3:0] CFG_REV = 4'h0;
  localparam logic [3:0] CFG_ISA = 4'h2;
  localparam logic [3:0] CFG_DBG = 4'h9;
  localparam logic [3:0] CFG1_MARK = 4'h1;
  // Sequencer states, Gray along boot path
  typedef enum logic [2:0] {
    ST_CFG = 3'h0,
    ST_RSP = 3'h1,
    ST_RPC = 3'h3,
    ST_RUN = 3'h2,
    ST_RTE1 = 3'h6,
    ST_RTE2 = 3'h7,
    ST_INTERRUPT_ACKNOWLEDGE_CYCLE = 3'h5,
    ST_HALT = 3'h4
  } cxr_state_e;
endpackage

/* File: sim/cxr_bus_model.sv */
// Memory bus and interrupt controller partner model
`timescale 1ns/10ps
module cxr_bus_model (
  input wire logic sys_clk_i,
  input wire logic mem_req_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic interrupt_acknowledge_cycle_req_o,
  output logic mem_ack_i,
  output logic mem_err_i,
  output logic [31:0] mem_rdata_i,
  output logic interrupt_acknowledge_cycle_done_i,
  output logic [7:0] interrupt_acknowledge_cycle_vector_i
);
  logic [31:0] mem [16];
  logic err_next = 1'b0;
  logic slow = 1'b0;
  logic wt = 1'b0;
  // Quiet outputs at time zero
  initial {mem_ack_i, mem_err_i, interrupt_acknowledge_cycle_done_i, mem_rdata_i, interrupt_acknowledge_cycle_vector_i} = '0;
  // answers longword reads
  // Prompt and delayed answers alternate; idle data toggles so stale reads show
  always @(posedge sys_clk_i) begin
    mem_ack_i <= 1'b0;
    mem_err_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (mem_req_o && !mem_ack_i && !mem_err_i) begin
      if (slow && !wt) begin
        wt <= 1'b1;
      end else begin
        wt <= 1'b0;
        slow <= !slow;
        mem_ack_i <= !err_next;
        mem_err_i <= err_next;
        mem_rdata_i <= mem[mem_addr_o[5:2]];
      end
    end
  end
  always @(posedge sys_clk_i) begin
    interrupt_acknowledge_cycle_done_i <= interrupt_acknowledge_cycle_req_o && !interrupt_acknowledge_cycle_done_i;
    interrupt_acknowledge_cycle_vector_i <= interrupt_acknowledge_cycle_req_o ? 8'h55 : ~interrupt_acknowledge_cycle_vector_i;
  end
endmodule

/* File: sim/core_exception_reset_unit_bench.sv */
// Self-checking bench for the core exception and reset unit
`timescale 1ns/10ps
module core_exception_reset_unit_bench;
  logic sys_clk_i = 0, rst_n_i = 0, force_reset_i = 0, ctl_we_i = 0, vbr_we_i = 0, fault_i = 0;
  logic op_valid_i = 0, op_undef_i = 0, op_rte_i = 0, op_trap_i = 0, bkpt_i = 0;
  logic exc_done_i = 0, irq_pending_i = 0;
  logic [31:0] ctl_wdata_i = 0, op_pc_i = 0, sp_i = 0, r, t;
  logic [15:0] opword_i = 0, status_word_o;
  logic [3:0] op_trap_num_i = 0, fmt;
  logic [2:0] irq_level_i = 0;
  logic [7:0] irq_vector_i = 0, interrupt_acknowledge_cycle_vector_i, exc_vector_o;
  logic mem_ack_i, mem_err_i, interrupt_acknowledge_cycle_done_i, mem_req_o, interrupt_acknowledge_cycle_req_o, exc_take_o, exc_keep_frame_o;
  logic pc_load_o, sp_load_o, reset_req_o, halted_o;
  logic [31:0] mem_rdata_i, mem_addr_o, exc_pc_o, pc_o, sp_o, vector_base_o, cpu_control_word_o;
  logic [31:0] core_config_word_o, mem_config_word_o;
  logic [42:0] exp_q [$];
  integer n_mismatch = 0, checks = 0, seed = 32'hd8e7e5e4, i;

  always #2 sys_clk_i = ~sys_clk_i;

  cxr_exception_unit #(.FAMILY_CODE(8'h3c)) i_dut (.sys_clk_i, .rst_n_i, .force_reset_i, .ctl_we_i,
    .vbr_we_i, .ctl_wdata_i, .op_valid_i, .opword_i, .op_undef_i, .op_rte_i, .op_trap_i, .op_trap_num_i,
    .op_pc_i, .sp_i, .bkpt_i, .fault_i, .exc_done_i, .irq_pending_i, .irq_level_i, .irq_vector_i,
    .interrupt_acknowledge_cycle_done_i, .interrupt_acknowledge_cycle_vector_i, .mem_ack_i, .mem_err_i, .mem_rdata_i, .mem_req_o, .mem_addr_o,
    .interrupt_acknowledge_cycle_req_o, .exc_take_o, .exc_vector_o, .exc_pc_o, .exc_keep_frame_o, .pc_load_o, .pc_o,
    .sp_load_o, .sp_o, .status_word_o, .vector_base_o, .cpu_control_word_o, .core_config_word_o,
    .mem_config_word_o, .reset_req_o, .halted_o);

  cxr_bus_model i_mem (.sys_clk_i, .mem_req_o, .mem_addr_o, .interrupt_acknowledge_cycle_req_o, .mem_ack_i, .mem_err_i,
    .mem_rdata_i, .interrupt_acknowledge_cycle_done_i, .interrupt_acknowledge_cycle_vector_i);

  task automatic chk(input logic [42:0] got, input logic [42:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Kinds: 0 exception, 1 PC load, 2 stack load, 3 internal reset
  function automatic void ex(input logic [1:0] k, input logic [40:0] v);
    exp_q.push_back({k, v});
  endfunction

  task automatic pop(input logic [42:0] got);
    if (exp_q.size() == 0) chk(got, ~got);
    else chk(got, exp_q.pop_front());
  endtask

  // Result watcher; the return PC only matters on a kept frame
  always @(negedge sys_clk_i) begin
    if (exc_take_o === 1'b1) pop({2'd0, exc_keep_frame_o, exc_vector_o, exc_keep_frame_o ? exc_pc_o : 32'h0});
    if (pc_load_o === 1'b1) pop({2'd1, 9'h0, pc_o});
    if (sp_load_o === 1'b1) pop({2'd2, 9'h0, sp_o});
    if (reset_req_o === 1'b1) pop({2'd3, 41'h0});
  end

  task automatic drain(input string s);
    int k;
    repeat (8) @(negedge sys_clk_i);
    for (k = 0; k < 60 && exp_q.size() > 0; k++) @(negedge sys_clk_i);
    chk(43'(exp_q.size()), 43'h0);
    exc_done_i = 1'b1;
    @(negedge sys_clk_i);
    exc_done_i = 1'b0;
    $display("test %s done", s);
  endtask

  task automatic op(input logic [15:0] w, input logic u, input logic rt, input logic tr, input logic [3:0] n);
    {opword_i, op_undef_i, op_rte_i, op_trap_i, op_trap_num_i, op_pc_i} = {w, u, rt, tr, n, r};
    op_valid_i = 1'b1;
    @(negedge sys_clk_i);
    {op_valid_i, op_undef_i, op_rte_i, op_trap_i, bkpt_i} = 5'h0;
    @(negedge sys_clk_i);
  endtask

  task automatic wr(input logic vb, input logic [31:0] d);
    {ctl_we_i, vbr_we_i, ctl_wdata_i} = {!vb, vb, d};
    @(negedge sys_clk_i);
    {ctl_we_i, vbr_we_i} = 2'b00;
    @(negedge sys_clk_i);
  endtask

  task automatic boot(input logic f, input logic g);
    i_mem.err_next = !g;
    if (g) begin
      ex(2, {9'h0, i_mem.mem[0]});
      ex(1, {9'h0, i_mem.mem[1]});
    end
    {rst_n_i, force_reset_i} = {f, f};
    repeat (8) @(negedge sys_clk_i);
    chk(43'(status_word_o), 43'h2700);
    chk(43'(cpu_control_word_o), 43'h0);
    chk(43'(vector_base_o), 43'h0);
    {rst_n_i, force_reset_i} = 2'b10;
    drain("boot");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    i_mem.mem[0] = 32'h0000_0400;
    i_mem.mem[1] = 32'h0000_1000;
    sp_i = 32'h20;
    boot(1'b0, 1'b1);
    chk(43'(core_config_word_o), 43'(32'h3c10_4029));
    chk(43'(mem_config_word_o), 43'(32'h1000_1000));
    r = $random(seed);
    wr(1'b0, {r[31:3], 3'b011});
    wr(1'b1, r);
    chk(43'({vector_base_o, cpu_control_word_o[10:0]}), {r, 11'h3});
    // Undefined lines trap, a defined one passes
    for (i = 0; i < 2; i++) begin
      r = $random(seed);
      ex(0, {1'b0, i ? 8'h0b : 8'h0a, 32'h0});
      op({i ? 4'hf : 4'ha, r[11:0]}, 1'b1, 1'b0, 1'b0, 4'h0);
      op(16'ha000, 1'b0, 1'b0, 1'b0, 4'h0);
      drain("line");
    end
    for (i = 0; i < 16; i++) begin
      ex(0, {1'b0, 8'h20 + 8'(i), 32'h0});
      op(16'h4e40, 1'b0, 1'b0, 1'b1, 4'(i));
      drain("trap");
    end
    r = $random(seed);
    fmt = 4'h4 + 4'(r[1:0]);
    t = $random(seed);
    i_mem.mem[8] = {fmt, 12'h0, 16'h1300};
    i_mem.mem[9] = t;
    ex(1, {9'h0, t});
    ex(2, {9'h0, 32'h24 + 32'(fmt)});
    op(16'h4e73, 1'b0, 1'b1, 1'b0, 4'h0);
    drain("return");
    chk(43'(status_word_o), 43'h1300);
    bkpt_i = 1'b1;
    ex(0, {1'b0, 8'h0c, 32'h0});
    op(16'h4e71, 1'b0, 1'b0, 1'b0, 4'h0);
    drain("breakpoint");
    chk(43'(status_word_o), 43'h3300);
    // Bad formats at both edges of the legal range
    for (i = 0; i < 2; i++) begin
      i_mem.mem[8] = {i ? 4'h8 : 4'h3, 28'h0001300};
      r = $random(seed);
      ex(0, {1'b1, 8'h0e, r});
      op(16'h4e73, 1'b0, 1'b1, 1'b0, 4'h0);
      drain("format");
    end
    {irq_pending_i, irq_level_i, irq_vector_i} = {1'b1, 3'h5, 8'h40};
    ex(0, {1'b0, 8'h40, 32'h0});
    op(16'h4e71, 1'b0, 1'b0, 1'b0, 4'h0);
    irq_level_i = 3'h4;
    drain("irq");
    chk(43'(status_word_o), 43'h2500);
    op(16'h4e71, 1'b0, 1'b0, 1'b0, 4'h0);
    {irq_level_i, irq_vector_i} = {3'h7, 8'h41};
    drain("masked");
    ex(0, {1'b0, 8'h41, 32'h0});
    op(16'h4e71, 1'b0, 1'b0, 1'b0, 4'h0);
    drain("sample");
    wr(1'b0, 32'h7);
    ex(0, {1'b0, 8'h55, 32'h0});
    op(16'h4e71, 1'b0, 1'b0, 1'b0, 4'h0);
    irq_pending_i = 1'b0;
    drain("ack");
    ex(0, {1'b0, 8'h23, 32'h0});
    op(16'h4e40, 1'b0, 1'b0, 1'b1, 4'h3);
    fault_i = 1'b1;
    @(negedge sys_clk_i);
    fault_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    chk(43'(halted_o), 43'h1);
    boot(1'b1, 1'b1);
    // Disabled bits cleared by reset: line A, bad format and fault during a trap reset the core
    for (i = 0; i < 3; i++) begin
      if (i == 2) ex(0, {1'b0, 8'h20, 32'h0});
      ex(3, 41'h0);
      ex(2, {9'h0, i_mem.mem[0]});
      ex(1, {9'h0, i_mem.mem[1]});
      op(i == 0 ? 16'ha123 : (i == 1 ? 16'h4e73 : 16'h4e40), 1'(i == 0), 1'(i == 1), 1'(i == 2), 4'h0);
      fault_i = 1'(i == 2);
      @(negedge sys_clk_i);
      fault_i = 1'b0;
      drain("self reset");
    end
    // Fault before the first instruction halts
    fault_i = 1'b1;
    @(negedge sys_clk_i);
    fault_i = 1'b0;
    chk(43'(halted_o), 43'h1);
    boot(1'b0, 1'b0);
    chk(43'(halted_o), 43'h1);
    give_verdict();
  end
endmodule
